// File: inc/fp_special_defines.svh
// Offsets, field positions, reset values and float constants of the special-value unit
// Assumes byte addressing on a 32-bit register bus
`ifndef FP_SPECIAL_DEFINES_SVH
`define FP_SPECIAL_DEFINES_SVH

// ==========================================================
// Register map
`define CTRL_OFS 4'h0
`define STATE_OFS 4'h4
`define CTRL_RMODE_LSB 4
`define CTRL_DENORM_BIT 7
`define CTRL_EXC_EN_BIT 9
`define CTRL_WMASK 32'h0000_02b0
`define CTRL_RESET 32'h0000_0000
`define STATE_RESET 5'h00

// ==========================================================
// Exception flag positions
`define EXC_INV 0
`define EXC_DZ 1
`define EXC_UF 2
`define EXC_OF 3
`define EXC_NX 4

// ==========================================================
// Float encodings and integer limits
`define SP_QBIT 22
`define SP_INT_EXP 8'h96
`define SP_INF 32'h7f80_0000
`define SP_FMAX 32'h7f7f_ffff
`define SP_EXP_TOP 8'h9e
`define HALF_INF 16'h7c00
`define HALF_FMAX 16'h7bff
`define HALF_BIAS 6'h0f
`define HALF_EMAX 6'h0f
`define I32_MAX 32'h7fff_ffff
`define I32_MIN 32'h8000_0000
`define U32_MAX 32'hffff_ffff

`endif

// File: inc/fp_special_pkg.sv
// Types and shared decode functions of the special-value unit
// Assumes the defines header is on the include path
`include "fp_special_defines.svh"

package fp_special_pkg;

    typedef enum logic [1:0] {
        round_nearest_even = 2'b00,
        round_toward_plus = 2'b01,
        round_toward_minus = 2'b10,
        round_toward_zero = 2'b11
    } rmode_t;

    typedef enum logic [3:0] {
        op_raw_move = 4'b0000,
        op_move = 4'b0001,
        op_min = 4'b0010,
        op_max = 4'b0011,
        op_round_int = 4'b0100,
        op_to_sint = 4'b0101,
        op_to_uint = 4'b0110,
        op_to_single = 4'b0111,
        op_to_half = 4'b1000,
        op_zero_sum = 4'b1001,
        op_overflow = 4'b1010
    } op_t;

    typedef enum logic [1:0] {
        mod_none = 2'b00,
        mod_neg = 2'b01,
        mod_abs = 2'b10,
        mod_neg_abs = 2'b11
    } mod_t;

    function automatic logic is_nan(input logic [31:0] v);
        return (&v[30:23]) && (|v[22:0]);
    endfunction : is_nan

    function automatic logic is_snan(input logic [31:0] v);
        return is_nan(v) && !v[`SP_QBIT];
    endfunction : is_snan

    function automatic logic [31:0] quiet(input logic [31:0] v);
        return {v[31:23], 1'b1, v[21:0]};
    endfunction : quiet

    function automatic logic [31:0] apply_mod(input logic [31:0] v, input mod_t m);
        unique case (m)
            mod_none: return v;
            mod_neg: return {~v[31], v[30:0]};
            mod_abs: return {1'b0, v[30:0]};
            mod_neg_abs: return {1'b1, v[30:0]};
        endcase
    endfunction : apply_mod

    function automatic logic round_inc(input rmode_t m, input logic sgn, input logic lsb,
                                       input logic g, input logic s);
        unique case (m)
            round_nearest_even: return g && (s || lsb);
            round_toward_plus: return !sgn && (g || s);
            round_toward_minus: return sgn && (g || s);
            round_toward_zero: return 1'b0;
        endcase
    endfunction : round_inc

    function automatic logic overflow_to_inf(input rmode_t m, input logic sgn);
        unique case (m)
            round_nearest_even: return 1'b1;
            round_toward_plus: return !sgn;
            round_toward_minus: return sgn;
            round_toward_zero: return 1'b0;
        endcase
    endfunction : overflow_to_inf

endpackage : fp_special_pkg

// File: rtl/float_int_core.sv
// Rounds a single-precision value to an integer magnitude in a given mode
// Assumes NaN and infinity are sorted out by the caller
`timescale 1ns/1ps

module float_int_round
    import fp_special_pkg::*;
#(
    parameter int INT_W = 32
) (
    input wire logic [31:0] src,
    input wire rmode_t mode,
    input wire logic denorm_en,
    output logic [INT_W:0] mag,
    output logic huge,
    output logic inexact
);

    logic [7:0] e;
    logic [7:0] sh;
    logic [23:0] m;
    logic [48:0] ext;
    logic [INT_W-1:0] ip;
    logic g;
    logic s;

    // ==========================================================
    // Alignment and rounding
    always_comb begin
        e = src[30:23];
        m = {1'b1, src[22:0]};
        sh = 8'h00;
        ext = '0;
        ip = '0;
        g = 1'b0;
        s = 1'b0;
        huge = 1'b0;
        if (e == 8'h00) begin
            s = denorm_en && (|src[22:0]);
        end else if (e == 8'hff) begin
            huge = 1'b1;
        end else if (e >= `SP_INT_EXP) begin
            sh = e - `SP_INT_EXP;
            if (int'(sh) > INT_W - 24) begin
                huge = 1'b1;
            end else begin
                ip = INT_W'(m) << sh;
            end
        end else begin
            sh = `SP_INT_EXP - e;
            if (sh > 8'h19) begin
                s = 1'b1;
            end else begin
                ext = {m, 25'h0} >> sh;
                ip = INT_W'(ext[48:25]);
                g = ext[24];
                s = |ext[23:0];
            end
        end
        mag = {1'b0, ip} + (INT_W+1)'(round_inc(mode, src[31], ip[0], g, s));
        inexact = g || s;
    end

endmodule : float_int_round

// File: rtl/fp_special_unit.sv
// Float special-value, rounding and conversion unit with thread control registers
// Assumes one issued operation per enabled cycle and an Avalon-MM master
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps

module fp_special_unit
    import fp_special_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic thread_load,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic op_valid,
    input wire op_t op_code,
    input wire mod_t op_mod_a,
    input wire mod_t op_mod_b,
    input wire rmode_t op_round_dir,
    input wire logic op_signed,
    input wire logic [31:0] src_a,
    input wire logic [31:0] src_b,
    output logic res_valid,
    output logic [31:0] res_data,
    output logic [4:0] res_exc
);

    logic [31:0] ctrl_q;
    logic [4:0] flags_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic res_valid_q;
    logic [31:0] res_q;
    logic [4:0] exc_q;
    logic [31:0] res_d;
    logic [4:0] exc_d;
    logic [31:0] a;
    logic [31:0] b;
    rmode_t rmode;
    rmode_t rint_mode;
    logic denorm_en;
    logic exc_en;
    logic [32:0] rint_mag;
    logic rint_huge;
    logic rint_nx;
    logic cv_neg;
    logic [31:0] cv_mag;
    logic [4:0] lz;
    logic found;
    logic [31:0] norm;
    logic [24:0] sm;
    logic [31:0] s_res;
    logic [11:0] hm;
    logic [5:0] he;
    logic h_ovf;
    logic [15:0] h_res;
    logic na;
    logic nb;
    logic sa;
    logic sb;
    logic pick_b;
    logic bus_wr;
    logic [31:0] wmask;

    assign rmode = rmode_t'(ctrl_q[`CTRL_RMODE_LSB +: 2]);
    assign denorm_en = ctrl_q[`CTRL_DENORM_BIT];
    assign exc_en = ctrl_q[`CTRL_EXC_EN_BIT];
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign res_valid = res_valid_q;
    assign res_data = res_q;
    assign res_exc = exc_q;
    assign bus_wr = avs_write && !wait_q;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ==========================================================
    // Operand decode and integer rounding unit
    assign a = apply_mod(src_a, op_mod_a);
    assign b = apply_mod(src_b, op_mod_b);
    assign rint_mode = (op_code == op_round_int) ? op_round_dir : rmode;
    assign na = is_nan(a);
    assign nb = is_nan(b);
    assign sa = is_snan(a);
    assign sb = is_snan(b);

    float_int_round #(.INT_W(32)) u_rint (
        .src(a),
        .mode(rint_mode),
        .denorm_en(denorm_en),
        .mag(rint_mag),
        .huge(rint_huge),
        .inexact(rint_nx)
    );

    // ==========================================================
    // Integer to float normalise and round
    always_comb begin
        cv_neg = (op_code == op_round_int) ? a[31] : (op_signed && src_a[31]);
        if (op_code == op_round_int) begin
            cv_mag = rint_mag[31:0];
        end else if (cv_neg) begin
            cv_mag = 32'h0 - src_a;
        end else begin
            cv_mag = src_a;
        end
        lz = 5'h00;
        found = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (!found && cv_mag[i]) begin
                lz = 5'(31 - i);
                found = 1'b1;
            end
        end
        norm = cv_mag << lz;
        sm = {1'b0, norm[31:8]} + 25'(round_inc(rint_mode, cv_neg, norm[8], norm[7],
                                                |norm[6:0]));
        s_res = {cv_neg, `SP_EXP_TOP - 8'(lz) + 8'(sm[24]), sm[24] ? 23'h0 : sm[22:0]};
        if (cv_mag == 32'h0) begin
            s_res = 32'h0;
        end
        hm = {1'b0, norm[31:21]} + 12'(round_inc(rint_mode, cv_neg, norm[21], norm[20],
                                                 |norm[19:0]));
        he = 6'h1f - 6'(lz) + 6'(hm[11]);
        h_ovf = he > `HALF_EMAX;
        if (cv_mag == 32'h0) begin
            h_res = 16'h0;
        end else if (h_ovf) begin
            h_res = overflow_to_inf(rint_mode, cv_neg) ? {cv_neg, 15'(`HALF_INF)}
                                                       : {cv_neg, 15'(`HALF_FMAX)};
        end else begin
            h_res = {cv_neg, 5'(he + `HALF_BIAS), hm[11] ? 10'h0 : hm[9:0]};
        end
    end

    // ==========================================================
    // Result and exception select
    always_comb begin
        res_d = a;
        exc_d = 5'h00;
        pick_b = (op_code == op_min) ?
                 ((b[31] != a[31]) ? b[31] : (b[31] ? b[30:0] > a[30:0] : b[30:0] < a[30:0])) :
                 ((b[31] != a[31]) ? a[31] : (a[31] ? a[30:0] > b[30:0] : a[30:0] < b[30:0]));
        unique case (op_code)
            op_raw_move: begin
                res_d = src_a;
            end
            op_move: begin
                res_d = sa ? quiet(a) : a;
                exc_d[`EXC_INV] = sa;
            end
            op_min, op_max: begin
                if (na && nb) begin
                    res_d = (!sa && sb) ? quiet(b) : quiet(a);
                    exc_d[`EXC_INV] = sa || sb;
                end else if (na) begin
                    res_d = (sa && denorm_en) ? quiet(a) : b;
                    exc_d[`EXC_INV] = sa && denorm_en;
                end else if (nb) begin
                    res_d = (sb && denorm_en) ? quiet(b) : a;
                    exc_d[`EXC_INV] = sb && denorm_en;
                end else begin
                    res_d = pick_b ? b : a;
                end
            end
            op_round_int: begin
                if (na) begin
                    res_d = quiet(a);
                    exc_d[`EXC_INV] = sa;
                end else if (a[30:23] >= `SP_INT_EXP) begin
                    res_d = a;
                end else if (rint_mag == 33'h0) begin
                    res_d = {a[31], 31'h0};
                end else begin
                    res_d = {a[31], s_res[30:0]};
                end
            end
            op_to_sint: begin
                exc_d[`EXC_INV] = 1'b1;
                if (na) begin
                    res_d = 32'h0;
                end else if (!a[31]) begin
                    if (rint_huge || rint_mag > {1'b0, `I32_MAX}) begin
                        res_d = `I32_MAX;
                    end else begin
                        res_d = rint_mag[31:0];
                        exc_d = {rint_nx, 4'h0};
                    end
                end else if (rint_huge || rint_mag > {1'b0, `I32_MIN}) begin
                    res_d = `I32_MIN;
                end else begin
                    res_d = 32'h0 - rint_mag[31:0];
                    exc_d = {rint_nx, 4'h0};
                end
            end
            op_to_uint: begin
                res_d = 32'h0;
                exc_d[`EXC_INV] = 1'b1;
                if (na) begin
                    res_d = 32'h0;
                end else if (!a[31]) begin
                    if (rint_huge || rint_mag[32]) begin
                        res_d = `U32_MAX;
                    end else begin
                        res_d = rint_mag[31:0];
                        exc_d = {rint_nx, 4'h0};
                    end
                end else if (a[30:23] == 8'h00) begin
                    exc_d = 5'h10;
                end
            end
            op_to_single: begin
                res_d = s_res;
                exc_d[`EXC_NX] = |norm[7:0];
            end
            op_to_half: begin
                res_d = {16'h0, h_res};
                exc_d[`EXC_OF] = h_ovf && (cv_mag != 32'h0);
                exc_d[`EXC_NX] = (|norm[20:0]) || exc_d[`EXC_OF];
            end
            op_zero_sum: begin
                if (a[31] == b[31] && a[30:0] == 31'h0 && b[30:0] == 31'h0) begin
                    res_d = {a[31], 31'h0};
                end else begin
                    res_d = {rmode == round_toward_minus, 31'h0};
                end
            end
            op_overflow: begin
                res_d = {a[31],
                         31'(overflow_to_inf(rmode, a[31]) ? `SP_INF : `SP_FMAX)};
                exc_d = 5'h18;
            end
            default: begin
                res_d = 32'h0;
            end
        endcase
    end

    // ==========================================================
    // Result register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            res_valid_q <= 1'b0;
            res_q <= 32'h0;
            exc_q <= 5'h00;
        end else if (ce) begin
            res_valid_q <= op_valid;
            if (op_valid) begin
                res_q <= res_d;
                exc_q <= exc_d;
            end
        end
    end

    // ==========================================================
    // Thread control register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (ce) begin
            if (thread_load) begin
                ctrl_q <= `CTRL_RESET;
            end else if (bus_wr && avs_address == `CTRL_OFS) begin
                ctrl_q <= (ctrl_q & ~(wmask & `CTRL_WMASK)) |
                          (avs_writedata & wmask & `CTRL_WMASK);
            end
        end
    end

    // ==========================================================
    // Sticky exception flags, write one to clear, set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_q <= `STATE_RESET;
        end else if (ce) begin
            if (thread_load) begin
                flags_q <= `STATE_RESET;
            end else begin
                flags_q <= (flags_q & ~((bus_wr && avs_address == `STATE_OFS &&
                            avs_byteenable[0]) ? avs_writedata[4:0] : 5'h00)) |
                           ((op_valid && exc_en) ? exc_d : 5'h00);
            end
        end
    end

    // ==========================================================
    // Avalon slave: one wait state on every access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else if (ce) begin
            if ((avs_read || avs_write) && wait_q) begin
                wait_q <= 1'b0;
                unique case (avs_address)
                    `CTRL_OFS: rdata_q <= ctrl_q & `CTRL_WMASK;
                    `STATE_OFS: rdata_q <= {27'h0, flags_q};
                    default: rdata_q <= 32'h0;
                endcase
            end else begin
                wait_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_raw_pass: assert property (ce && op_valid && op_code == op_raw_move
        |=> res_q == $past(src_a) && exc_q == 5'h00) else $error("raw move altered");
    a_snan_quiet: assert property (ce && op_valid && op_code == op_move && sa
        |=> res_q[`SP_QBIT] && exc_q[`EXC_INV]) else $error("sNaN not quietized");
    a_qnan_silent: assert property (ce && op_valid && op_code == op_move && na && !sa
        |=> exc_q == 5'h00 && res_q == $past(a)) else $error("qNaN not silent");
    a_payload_keep: assert property (ce && op_valid && op_code == op_move && na
        |=> res_q[21:0] == $past(src_a[21:0])) else $error("payload changed");
    a_zero_down: assert property (ce && op_valid && op_code == op_zero_sum && a == 32'h0 &&
        b == 32'h8000_0000 && rmode == round_toward_minus
        |=> res_q == 32'h8000_0000) else $error("zero sign wrong");
    a_ovf_nearest: assert property (ce && op_valid && op_code == op_overflow && !a[31] &&
        rmode == round_nearest_even |=> res_q == `SP_INF) else $error("ovf not inf");
    a_rnd_exact: assert property (ce && op_valid && op_code == op_round_int
        |=> exc_q[4:1] == 4'h0) else $error("round-integral flagged");
    a_sint_nan: assert property (ce && op_valid && op_code == op_to_sint && na
        |=> res_q == 32'h0 && exc_q == 5'h01) else $error("NaN to int wrong");
    a_flag_gate: assert property (ce && !exc_en && !thread_load && !bus_wr
        |=> flags_q == $past(flags_q)) else $error("flags moved while disabled");
    a_flag_set: assert property (ce && op_valid && exc_en && !thread_load && exc_d[`EXC_INV]
        |=> flags_q[`EXC_INV] [*2]) else $error("invalid flag lost");

    c_snan_move: cover property (ce && op_valid && op_code == op_move && sa);
    c_minmax_nan: cover property (ce && op_valid && op_code == op_min && na && nb);
    c_half_ovf: cover property (ce && op_valid && op_code == op_to_half && h_ovf);
    c_bus_read: cover property (avs_read && !wait_q);

endmodule : fp_special_unit

// File: verif/issue_model.sv
// Issue-side model: drives one operation per call and collects its result
// Assumes ce is high and one result returns the cycle after issue
`timescale 1ns/1ps

module issue_model
    import fp_special_pkg::*;
(
    input wire logic mclk,
    output logic op_valid,
    output op_t op_code,
    output mod_t op_mod_a,
    output mod_t op_mod_b,
    output rmode_t op_round_dir,
    output logic op_signed,
    output logic [31:0] src_a,
    output logic [31:0] src_b,
    input wire logic res_valid,
    input wire logic [31:0] res_data,
    input wire logic [4:0] res_exc
);
    // ==========================================================
    // Idle levels
    initial begin
        op_valid = 1'b0;
        op_code = op_raw_move;
        op_mod_a = mod_none;
        op_mod_b = mod_none;
        op_round_dir = round_nearest_even;
        op_signed = 1'b0;
        src_a = 32'h0;
        src_b = 32'h0;
    end

    // ==========================================================
    // One issue, then wait a bounded time for the result
    task automatic send(input op_t o, input mod_t m, input rmode_t d, input logic s,
                        input logic [31:0] a, input logic [31:0] b,
                        output logic [31:0] r, output logic [4:0] e);
        r = 'x;
        e = 'x;
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= o;
        op_mod_a <= m;
        op_mod_b <= m;
        op_round_dir <= d;
        op_signed <= s;
        src_a <= a;
        src_b <= b;
        @(posedge mclk);
        op_valid <= 1'b0;
        // Released operands must not keep their last value
        src_a <= ~a;
        src_b <= ~b;
        // Result stands for exactly the one cycle after the capture edge
        @(posedge mclk);
        if (res_valid === 1'b1) begin
            r = res_data;
            e = res_exc;
        end
    endtask : send
endmodule : issue_model

// File: verif/tb_top.sv
// Self-checking bench: register access over Avalon-MM and operations through the issue model
// Assumes the design package and the issue model are compiled first
`timescale 1ns/1ps

module tb_top
    import fp_special_pkg::*;
();
    localparam rmode_t r_ne = round_nearest_even;
    localparam rmode_t r_up = round_toward_plus;
    localparam rmode_t r_dn = round_toward_minus;
    localparam rmode_t r_tz = round_toward_zero;
    logic mclk, rst, thread_load, avs_read, avs_write, op_valid, op_signed, res_valid, dn;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, src_a, src_b, res_data, ctrl_v, q;
    logic avs_waitrequest;
    logic [4:0] res_exc, flags_v, e;
    op_t op_code;
    mod_t op_mod_a, op_mod_b, md;
    rmode_t op_round_dir;
    int error_cnt, num_checks, cyc;

    fp_special_unit dut (.mclk(mclk), .rst(rst), .ce(1'b1), .thread_load(thread_load),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .op_valid(op_valid), .op_code(op_code),
        .op_mod_a(op_mod_a), .op_mod_b(op_mod_b), .op_round_dir(op_round_dir),
        .op_signed(op_signed), .src_a(src_a), .src_b(src_b), .res_valid(res_valid),
        .res_data(res_data), .res_exc(res_exc));
    issue_model model (.mclk(mclk), .op_valid(op_valid), .op_code(op_code),
        .op_mod_a(op_mod_a), .op_mod_b(op_mod_b), .op_round_dir(op_round_dir),
        .op_signed(op_signed), .src_a(src_a), .src_b(src_b), .res_valid(res_valid),
        .res_data(res_data), .res_exc(res_exc));

    // ==========================================================
    // Clock and timeout
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test;
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Hold the request until waitrequest is sampled low
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic run(input rmode_t m, input op_t o, input rmode_t d, input logic s,
                       input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] er, input logic [4:0] ee);
        logic [31:0] cv;
        logic [31:0] r;
        cv = 32'h200 | {24'h0, dn, 1'b0, m, 4'h0};
        if (cv !== ctrl_v) begin
            bus(1'b1, 4'h0, cv, r);
            ctrl_v = cv;
        end
        model.send(o, md, d, s, a, b, r, e);
        chk(r, er);
        chk({27'h0, e}, {27'h0, ee});
        flags_v = flags_v | ee;
    endtask : run

    task automatic finish_test;
        $display("Checks: %0d, mismatches: %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // Main sequence
    initial begin
        {rst, thread_load, avs_read, avs_write, dn} = 5'h11;
        {avs_address, avs_writedata, ctrl_v, flags_v, cyc, error_cnt, num_checks} = '0;
        md = mod_none;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, 4'h0, 32'hffffffff, q);
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h2b0);
        bus(1'b1, 4'h0, 32'h0, q);
        bus(1'b0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
        model.send(op_move, md, r_ne, 0, 32'h7f800001, 32'h0, q, e);
        chk({27'h0, e}, 32'h1);
        bus(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h0);
        $display("Test registers done");
        run(r_ne, op_raw_move, r_ne, 0, 32'h7f800001, 32'h0, 32'h7f800001, 5'h00);
        run(r_ne, op_move, r_ne, 0, 32'h7f800001, 32'h0, 32'h7fc00001, 5'h01);
        run(r_ne, op_move, r_ne, 0, 32'hffc00005, 32'h0, 32'hffc00005, 5'h00);
        md = mod_abs;
        run(r_ne, op_move, r_ne, 0, 32'hff800003, 32'h0, 32'h7fc00003, 5'h01);
        md = mod_neg;
        run(r_ne, op_move, r_ne, 0, 32'h7fc00007, 32'h0, 32'hffc00007, 5'h00);
        md = mod_none;
        run(r_ne, op_min, r_ne, 0, 32'h3f800000, 32'h7fc00000, 32'h3f800000, 5'h00);
        run(r_ne, op_min, r_ne, 0, 32'hbf800000, 32'h3f800000, 32'hbf800000, 5'h00);
        run(r_ne, op_max, r_ne, 0, 32'h7f800002, 32'h3f800000, 32'h7fc00002, 5'h01);
        run(r_ne, op_min, r_ne, 0, 32'h7fc00001, 32'h7fc00002, 32'h7fc00001, 5'h00);
        run(r_ne, op_max, r_ne, 0, 32'h7fc00001, 32'h7f800002, 32'h7fc00002, 5'h01);
        run(r_ne, op_min, r_ne, 0, 32'h7f800003, 32'h7f800002, 32'h7fc00003, 5'h01);
        run(r_up, op_round_int, r_ne, 0, 32'h40200000, 32'h0, 32'h40000000, 5'h00);
        run(r_ne, op_round_int, r_dn, 0, 32'hbfc00000, 32'h0, 32'hc0000000, 5'h00);
        run(r_ne, op_round_int, r_tz, 0, 32'h4b000001, 32'h0, 32'h4b000001, 5'h00);
        run(r_ne, op_round_int, r_tz, 0, 32'h7f800001, 32'h0, 32'h7fc00001, 5'h01);
        run(r_ne, op_round_int, r_up, 0, 32'h00000001, 32'h0, 32'h3f800000, 5'h00);
        dn = 1'b0;
        run(r_ne, op_round_int, r_up, 0, 32'h00000001, 32'h0, 32'h00000000, 5'h00);
        run(r_ne, op_max, r_ne, 0, 32'h7f800002, 32'h3f800000, 32'h3f800000, 5'h00);
        dn = 1'b1;
        run(r_ne, op_to_sint, r_ne, 0, 32'h7fc00000, 32'h0, 32'h00000000, 5'h01);
        run(r_ne, op_to_sint, r_ne, 0, 32'h4f000000, 32'h0, 32'h7fffffff, 5'h01);
        run(r_ne, op_to_sint, r_ne, 0, 32'hff800000, 32'h0, 32'h80000000, 5'h01);
        run(r_ne, op_to_sint, r_ne, 0, 32'h3fc00000, 32'h0, 32'h00000002, 5'h10);
        run(r_dn, op_to_sint, r_ne, 0, 32'h3fc00000, 32'h0, 32'h00000001, 5'h10);
        run(r_ne, op_to_uint, r_ne, 0, 32'h80000000, 32'h0, 32'h00000000, 5'h10);
        run(r_ne, op_to_uint, r_ne, 0, 32'hbf800000, 32'h0, 32'h00000000, 5'h01);
        run(r_ne, op_to_single, r_ne, 0, 32'h01000001, 32'h0, 32'h4b800000, 5'h10);
        run(r_ne, op_to_single, r_ne, 1, 32'h00000000, 32'h0, 32'h00000000, 5'h00);
        run(r_ne, op_to_half, r_ne, 0, 32'h00010000, 32'h0, 32'h00007c00, 5'h18);
        run(r_tz, op_to_half, r_ne, 1, 32'hffff0000, 32'h0, 32'h0000fbff, 5'h18);
        run(r_ne, op_zero_sum, r_ne, 0, 32'h3f800000, 32'hbf800000, 32'h0, 5'h00);
        run(r_dn, op_zero_sum, r_ne, 0, 32'h00000000, 32'h80000000, 32'h80000000, 5'h00);
        run(r_ne, op_zero_sum, r_ne, 0, 32'h80000000, 32'h80000000, 32'h80000000, 5'h00);
        run(r_ne, op_overflow, r_ne, 0, 32'h3f800000, 32'h0, 32'h7f800000, 5'h18);
        run(r_tz, op_overflow, r_ne, 0, 32'h3f800000, 32'h0, 32'h7f7fffff, 5'h18);
        run(r_up, op_overflow, r_ne, 0, 32'hbf800000, 32'h0, 32'hff7fffff, 5'h18);
        run(r_dn, op_overflow, r_ne, 0, 32'hbf800000, 32'h0, 32'hff800000, 5'h18);
        $display("Test operations done");
        bus(1'b0, 4'h4, 32'h0, q);
        chk(q, {27'h0, flags_v});
        bus(1'b1, 4'h4, 32'h1f, q);
        bus(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h0);
        @(posedge mclk);
        thread_load <= 1'b1;
        @(posedge mclk);
        thread_load <= 1'b0;
        bus(1'b0, 4'h0, 32'h0, q);
        chk(q, 32'h0);
        $display("Test flags done");
        finish_test;
    end
endmodule : tb_top
